/* File: logic/rdiag_status.sv */
// module: reader diagnostic status counters and status replies
`timescale 1ns/1ps
`default_nettype none

module rdiag_status #(
  parameter int          PRES_STEP_CYCLES = rdiag_pkg::PRES_STEP_CYC,
  parameter logic [7:0]  MULTI_TAG_COUNT  = 8'h02
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // radio side events
  input  wire logic        tag_busy_i,
  input  wire logic        interference_i,
  input  wire logic        abort_err_i,
  input  wire logic        code_err_i,
  input  wire logic        code_err_to_crc_i,
  input  wire logic        sig_err_i,
  input  wire logic        crc_err_i,
  input  wire logic        active_err_i,
  input  wire logic        cmd_done_i,
  input  wire logic [7:0]  cmd_status_i,
  // host link faults
  input  wire logic        host_parity_err_i,
  input  wire logic        host_check_err_i,
  input  wire logic        host_frame_err_i,
  // tag data
  input  wire logic        tag_present_i,
  input  wire logic [31:0] tag_identifier_i,
  input  wire logic [1:0]  tag_fram_size_i,
  input  wire logic [7:0]  tag_lock_byte_i,
  input  wire logic [7:0]  field_strength_value_i,
  // outputs
  output logic             antenna_on_o,
  output logic             presence_indication_o,
  output logic             field_reliable_o,
  output logic [15:0]      lock_addr_o
);

  logic [31:0] ctrl;
  logic [7:0]  ev_cnt [rdiag_pkg::EV_NUM];
  logic [rdiag_pkg::EV_NUM-1:0] ev_inc;
  logic [7:0]  command_status;
  logic [7:0]  quality_passive;
  logic [7:0]  active_error_count;
  logic [7:0]  presence_time_count;
  logic [31:0] step_cnt;
  logic        tag_present_q;
  logic [31:0] reply0;
  logic [31:0] reply1;
  logic [31:0] reply2;
  logic        wr_now;
  logic        cmd_now;
  logic        reader_clear;
  logic        quality_clear;
  logic [7:0]  cmd_mode;
  logic [7:0]  tag_count_param;
  logic [7:0]  tag_family;
  logic        presence_en;
  logic [7:0]  mtag;
  logic [7:0]  antenna_state;
  logic [7:0]  presence_setting;
  logic [7:0]  tag_type;
  logic [31:0] next_rdata;

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == rdiag_pkg::CNT_MAX) ? v : v + 8'h01;
  endfunction : sat_inc

  // decoded control fields
  assign tag_count_param = ctrl[rdiag_pkg::CTRL_PARAM_LSB +: 8];
  assign tag_family      = ctrl[rdiag_pkg::CTRL_FAMILY_LSB +: 8];
  assign presence_en     = ctrl[rdiag_pkg::CTRL_PRES_BIT];
  assign antenna_on_o    = ctrl[rdiag_pkg::CTRL_ANT_BIT];
  assign lock_addr_o     = rdiag_pkg::LOCK_ADDR;

  // bus strobes: writes and commands act at the edge where ack is seen
  assign wr_now   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign cmd_now  = wr_now && (wb_adr_i == rdiag_pkg::CMD_OFS) && wb_sel_i[0];
  assign cmd_mode = wb_dat_i[7:0];
  assign reader_clear  = cmd_now && (cmd_mode == rdiag_pkg::MODE_READER);
  // tag exit or antenna off empties the quality counters
  assign quality_clear = (tag_present_q && !tag_present_i) || !antenna_on_o;

  // configuration status fields
  always_comb begin
    if (tag_count_param == rdiag_pkg::SINGLE_TAG_A ||
        tag_count_param == rdiag_pkg::SINGLE_TAG_B) begin
      mtag = rdiag_pkg::MTAG_SINGLE;
    end else begin
      mtag = MULTI_TAG_COUNT;
    end
  end

  assign antenna_state    = antenna_on_o ? rdiag_pkg::ANT_ON_CODE : rdiag_pkg::ANT_OFF_CODE;
  assign presence_setting = presence_en ? rdiag_pkg::PRES_ON : rdiag_pkg::PRES_OFF;
  assign presence_indication_o = presence_en && tag_present_i;
  assign field_reliable_o = field_strength_value_i < rdiag_pkg::FIELD_GOOD_LIMIT;

  always_comb begin
    case (tag_fram_size_i)
      2'b01:   tag_type = rdiag_pkg::TYPE_FRAM_8K;
      2'b10:   tag_type = rdiag_pkg::TYPE_FRAM_32K;
      default: tag_type = rdiag_pkg::TYPE_NO_FRAM;
    endcase
  end

  // event increments
  always_comb begin
    ev_inc = '0;
    ev_inc[rdiag_pkg::EV_PASSIVE] = interference_i && !tag_busy_i;
    ev_inc[rdiag_pkg::EV_ABORT]   = abort_err_i && tag_busy_i;
    ev_inc[rdiag_pkg::EV_CODE]    = code_err_i && tag_busy_i;
    // a code error always drags a secondary error with it
    ev_inc[rdiag_pkg::EV_SIG] = tag_busy_i &&
      (sig_err_i || (code_err_i && !code_err_to_crc_i));
    ev_inc[rdiag_pkg::EV_CRC] = tag_busy_i &&
      (crc_err_i || (code_err_i && code_err_to_crc_i));
    ev_inc[rdiag_pkg::EV_HOST] =
      host_parity_err_i || host_check_err_i || host_frame_err_i;
  end

  // reader counters: an event in the clearing cycle is kept as one
  generate
    for (genvar i = 0; i < rdiag_pkg::EV_NUM; i++) begin : g_ev
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ev_cnt[i] <= 8'h00;
        end else if (reader_clear) begin
          ev_cnt[i] <= ev_inc[i] ? 8'h01 : 8'h00;
        end else if (ev_inc[i]) begin
          ev_cnt[i] <= sat_inc(ev_cnt[i]);
        end
      end
    end
  endgenerate

  // last command status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      command_status <= 8'h00;
    end else if (cmd_done_i) begin
      command_status <= cmd_status_i;
    end else if (reader_clear) begin
      command_status <= 8'h00;
    end
  end

  // quality counters, live while the tag stays in the field
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tag_present_q <= 1'b0;
    end else begin
      tag_present_q <= tag_present_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || quality_clear) begin
      quality_passive <= 8'h00;
    end else if (ev_inc[rdiag_pkg::EV_PASSIVE]) begin
      quality_passive <= sat_inc(quality_passive);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || quality_clear) begin
      active_error_count <= 8'h00;
    end else if (active_err_i && tag_busy_i) begin
      active_error_count <= sat_inc(active_error_count);
    end
  end

  // presence time: one step per 10 ms while the tag is present
  always_ff @(posedge clk_i) begin
    if (rst_i || quality_clear || !tag_present_i) begin
      step_cnt <= 32'h0000_0000;
    end else if (step_cnt == 32'(PRES_STEP_CYCLES - 1)) begin
      step_cnt <= 32'h0000_0000;
    end else begin
      step_cnt <= step_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || quality_clear || !tag_present_i) begin
      presence_time_count <= 8'h00;
    end else if (step_cnt == 32'(PRES_STEP_CYCLES - 1)) begin
      presence_time_count <= sat_inc(presence_time_count);
    end
  end

  // control register, byte-lane writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= rdiag_pkg::CTRL_RESET;
    end else if (wr_now && wb_adr_i == rdiag_pkg::CTRL_OFS) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          ctrl[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  // replies snapshot on each status command; other modes leave them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reply0 <= 32'h0000_0000;
      reply1 <= 32'h0000_0000;
      reply2 <= 32'h0000_0000;
    end else if (cmd_now) begin
      if (cmd_mode == rdiag_pkg::MODE_READER) begin
        reply0 <= {ev_cnt[rdiag_pkg::EV_SIG], ev_cnt[rdiag_pkg::EV_CODE],
                   ev_cnt[rdiag_pkg::EV_ABORT], ev_cnt[rdiag_pkg::EV_PASSIVE]};
        reply1 <= {8'h00, ev_cnt[rdiag_pkg::EV_HOST], command_status,
                   ev_cnt[rdiag_pkg::EV_CRC]};
        reply2 <= 32'h0000_0000;
      end else if (cmd_mode == rdiag_pkg::MODE_IDENTITY) begin
        reply0 <= tag_identifier_i;
        reply1 <= 32'h0000_0000;
        reply2 <= {16'h0000, tag_lock_byte_i, tag_type};
      end else if (cmd_mode == rdiag_pkg::MODE_QUALITY) begin
        reply0 <= {presence_time_count, active_error_count,
                   quality_passive, field_strength_value_i};
        reply1 <= 32'h0000_0000;
        reply2 <= 32'h0000_0000;
      end
    end
  end

  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    if (wb_adr_i == rdiag_pkg::CTRL_OFS) begin
      next_rdata = ctrl;
    end else if (wb_adr_i == rdiag_pkg::CONFIG_OFS) begin
      next_rdata = {presence_setting, antenna_state,
                    (tag_family == rdiag_pkg::FAMILY_NATIVE) ? rdiag_pkg::FAMILY_NATIVE
                                                             : tag_family, mtag};
    end else if (wb_adr_i == rdiag_pkg::REPLY0_OFS) begin
      next_rdata = reply0;
    end else if (wb_adr_i == rdiag_pkg::REPLY1_OFS) begin
      next_rdata = reply1;
    end else if (wb_adr_i == rdiag_pkg::REPLY2_OFS) begin
      next_rdata = reply2;
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  // one wait state; ack drops the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      // data only alongside ack, so a held request never leaves stale data behind
      wb_dat_o <= (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) ? next_rdata
                                                                   : 32'h0000_0000;
    end
  end

endmodule : rdiag_status

`default_nettype wire

/* File: logic/rdiag_pkg.sv */
// package: register map, codes and timing for reader diagnostic status
package rdiag_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CONFIG_OFS = 8'h04;
  localparam logic [7:0] CMD_OFS    = 8'h08;
  localparam logic [7:0] REPLY0_OFS = 8'h0C;
  localparam logic [7:0] REPLY1_OFS = 8'h10;
  localparam logic [7:0] REPLY2_OFS = 8'h14;
  // control field positions
  localparam int CTRL_PARAM_LSB  = 0;
  localparam int CTRL_FAMILY_LSB = 8;
  localparam int CTRL_PRES_BIT   = 16;
  localparam int CTRL_ANT_BIT    = 17;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // command modes
  localparam logic [7:0] MODE_IDENTITY = 8'h01;
  localparam logic [7:0] MODE_QUALITY  = 8'h02;
  localparam logic [7:0] MODE_READER   = 8'h06;
  // single-tag parameter values
  localparam logic [7:0] SINGLE_TAG_A = 8'h05;
  localparam logic [7:0] SINGLE_TAG_B = 8'h25;
  localparam logic [7:0] MTAG_SINGLE  = 8'h01;
  // family codes
  localparam logic [7:0] FAMILY_NATIVE = 8'h00;
  localparam logic [7:0] FAMILY_ISO    = 8'h01;
  // antenna and presence codes
  localparam logic [7:0] ANT_ON_CODE  = 8'h01;
  localparam logic [7:0] ANT_OFF_CODE = 8'h02;
  localparam logic [7:0] PRES_OFF     = 8'h00;
  localparam logic [7:0] PRES_ON      = 8'h01;
  // tag type codes by ferroelectric memory size
  localparam logic [7:0] TYPE_NO_FRAM  = 8'h01;
  localparam logic [7:0] TYPE_FRAM_8K  = 8'h02;
  localparam logic [7:0] TYPE_FRAM_32K = 8'h03;
  localparam logic [15:0] LOCK_ADDR    = 16'hFF18;
  // field strength good threshold
  localparam logic [7:0] FIELD_GOOD_LIMIT = 8'h28;
  localparam logic [7:0] CNT_MAX          = 8'hFF;
  // presence time step
  localparam int CLK_HZ          = 20_000_000;
  localparam int PRES_STEP_MS    = 10;
  localparam int PRES_STEP_CYC   = CLK_HZ / 1000 * PRES_STEP_MS;
  // event counter indices
  localparam int EV_PASSIVE = 0;
  localparam int EV_ABORT   = 1;
  localparam int EV_CODE    = 2;
  localparam int EV_SIG     = 3;
  localparam int EV_CRC     = 4;
  localparam int EV_HOST    = 5;
  localparam int EV_NUM     = 6;
endpackage : rdiag_pkg

/* File: dv/rdiag_tag_model.sv */
// tag front end model feeding tag data to the status block
`timescale 1ns/1ps
`default_nettype none
module rdiag_tag_model #(
  parameter logic [31:0] TAG_ID    = 32'hA5C3_1E77,
  parameter logic [7:0]  LOCK_BYTE = 8'h96
) (
  // control from bench
  input  wire logic        present_i,
  input  wire logic [1:0]  fram_i,
  input  wire logic [7:0]  field_i,
  // tag data
  output logic             tag_present_o,
  output logic [31:0]      id_o,
  output logic [1:0]       fram_o,
  output logic [7:0]       lock_o,
  output logic [7:0]       field_o
);
  // absent tag: inverted data so stale values never pass
  assign tag_present_o = present_i;
  assign id_o          = present_i ? TAG_ID : ~TAG_ID;
  assign fram_o        = present_i ? fram_i : ~fram_i;
  assign lock_o        = present_i ? LOCK_BYTE : ~LOCK_BYTE;
  assign field_o       = present_i ? field_i : ~field_i;
endmodule : rdiag_tag_model
`default_nettype wire

/* File: dv/rdiag_status_monitor.sv */
// bus and status output checker for the diagnostic status block
`timescale 1ns/1ps
`default_nettype none
module rdiag_status_monitor (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // bus
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  // tag side and outputs
  input  wire logic        tag_present_i,
  input  wire logic [7:0]  field_strength_value_i,
  input  wire logic        antenna_on_o,
  input  wire logic        presence_indication_o,
  input  wire logic        field_reliable_o,
  input  wire logic [15:0] lock_addr_o
);
  logic ant_en;
  logic pres_en;
  wire logic wr_ctrl = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h00
                       && wb_sel_i[2];
  // shadow of the control bits, updated at the acknowledged write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ant_en  <= 1'b0;
      pres_en <= 1'b0;
    end else if (wr_ctrl) begin
      ant_en  <= wb_dat_i[17];
      pres_en <= wb_dat_i[16];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_field; field_reliable_o == (field_strength_value_i < 8'h28); endproperty
  property p_lock; lock_addr_o == 16'hFF18; endproperty
  property p_ind; presence_indication_o == (pres_en && tag_present_i); endproperty
  property p_ant; antenna_on_o == ant_en; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_dat_idle: assert property (p_dat_idle) else $error("data without ack");
  a_field: assert property (p_field) else $error("reliable flag wrong");
  a_lock: assert property (p_lock) else $error("lock address wrong");
  a_ind: assert property (p_ind) else $error("presence indication wrong");
  a_ant: assert property (p_ant) else $error("antenna state wrong");
  c_ant_on: cover property (wr_ctrl && wb_dat_i[17]);
  c_ind: cover property (presence_indication_o);
  c_weak: cover property (!field_reliable_o);
endmodule : rdiag_status_monitor
bind rdiag_status rdiag_status_monitor i_rdiag_status_monitor (.*);
`default_nettype wire

/* File: dv/rdiag_status_tb.sv */
// self-checking bench for the diagnostic status block
`timescale 1ns/1ps
`default_nettype none
module rdiag_status_tb;
  localparam logic [31:0] TAG_ID = 32'hA5C3_1E77;
  localparam logic [7:0]  LOCK   = 8'h96;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        busy, to_crc, present, tp, ant_o, ind_o, rel_o;
  logic [7:0]  wb_adr_i, cmd_status, field, lock, field_m;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, id;
  logic [9:0]  ev;
  logic [1:0]  fram, fram_m;
  logic [15:0] lock_addr;
  logic [7:0]  prm [3] = '{8'h05, 8'h25, 8'h07};
  logic [7:0]  typ [4] = '{8'h01, 8'h02, 8'h03, 8'h01};
  int          err_total, checked;
  rdiag_tag_model #(.TAG_ID(TAG_ID), .LOCK_BYTE(LOCK)) i_rdiag_tag_model (.present_i(present),
    .fram_i(fram), .field_i(field), .tag_present_o(tp), .id_o(id), .fram_o(fram_m),
    .lock_o(lock), .field_o(field_m));
  rdiag_status #(.PRES_STEP_CYCLES(4)) i_rdiag_status (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tag_busy_i(busy), .interference_i(ev[0]), .abort_err_i(ev[1]), .code_err_i(ev[2]),
    .code_err_to_crc_i(to_crc), .sig_err_i(ev[3]), .crc_err_i(ev[4]), .active_err_i(ev[5]),
    .cmd_done_i(ev[9]), .cmd_status_i(cmd_status), .host_parity_err_i(ev[6]),
    .host_check_err_i(ev[7]), .host_frame_err_i(ev[8]), .tag_present_i(tp),
    .tag_identifier_i(id), .tag_fram_size_i(fram_m), .tag_lock_byte_i(lock),
    .field_strength_value_i(field_m), .antenna_on_o(ant_o), .presence_indication_o(ind_o),
    .field_reliable_o(rel_o), .lock_addr_o(lock_addr));
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle; waits on ack, bounded
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 8);
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      results();
    end else begin
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic cmd(input logic [7:0] m);
    bus(1'b1, 8'h08, {24'h0, m});
  endtask : cmd
  task automatic pulse(input logic [9:0] m, input int n);
    repeat (n) begin
      @(posedge clk_i);
      ev <= m;
      @(posedge clk_i);
      ev <= 10'h0;
    end
  endtask : pulse
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, busy, to_crc, present} = 7'h40;
    {wb_adr_i, wb_dat_i, ev, fram, cmd_status} = '0;
    wb_sel_i = 4'hF;
    field = 8'h27;
    err_total = 0;
    checked = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(8'h00, 32'h0000_0000);
    rdchk(8'h04, 32'h0002_0002);
    rdchk(8'h20, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h00, {16'h0003, 8'h01, prm[i]});
      rdchk(8'h04, {24'h010101, (i == 2) ? 8'h02 : 8'h01});
    end
    pulse(10'h001, 3);
    pulse(10'h002, 1);
    busy <= 1'b1;
    pulse(10'h001, 2);
    pulse(10'h002, 1);
    pulse(10'h004, 1);
    to_crc <= 1'b1;
    pulse(10'h004, 1);
    pulse(10'h018, 1);
    cmd_status <= 8'h3C;
    pulse(10'h200, 1);
    for (int i = 0; i < 4; i++) pulse(i == 3 ? 10'h1C0 : 10'h040 << i, 1);
    cmd(8'h06);
    rdchk(8'h0C, 32'h0202_0103);
    rdchk(8'h10, 32'h0004_3C02);
    cmd(8'h06);
    rdchk(8'h0C, 32'h0);
    rdchk(8'h10, 32'h0);
    busy <= 1'b0;
    pulse(10'h001, 260);
    cmd(8'h06);
    rdchk(8'h0C, 32'h0000_00FF);
    present <= 1'b1;
    cmd(8'h06);
    for (int i = 0; i < 4; i++) begin
      fram <= i[1:0];
      cmd(8'h01);
      rdchk(8'h0C, TAG_ID);
      rdchk(8'h10, 32'h0);
      rdchk(8'h14, {16'h0, LOCK, typ[i]});
    end
    // antenna off holds the quality counters clear
    bus(1'b1, 8'h00, 32'h0001_0101);
    cmd(8'h02);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd & 32'hFFFF_FF00, 32'h0);
    bus(1'b1, 8'h00, 32'h0003_0101);
    busy <= 1'b1;
    pulse(10'h020, 2);
    busy <= 1'b0;
    pulse(10'h001, 1);
    field <= 8'h28;
    repeat (1100) @(posedge clk_i);
    cmd(8'h02);
    rdchk(8'h0C, 32'hFF02_0128);
    present <= 1'b0;
    cmd(8'h02);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd & 32'hFFFF_FF00, 32'h0);
    results();
  end
endmodule : rdiag_status_tb
`default_nettype wire
